// [src/hpf_framer.sv]
// host framer: framing mode, transparent packet cutting, notice gating, hop limit
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module hpf_framer #(
    parameter int CYCLES_PER_MS = hpf_pkg::HPF_CYCLES_PER_MS
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire hpf_pkg::hpf_char_t host_char,
    input wire logic spi_mode,
    input wire logic switch_to_structured_cmd,
    input wire logic return_transparent_cmd,
    input wire logic link_up,
    input wire logic remote_registered,
    input wire logic [7:0] remote_addr,
    input wire logic hop_start,
    input wire logic packet_sent,
    input wire logic ann_request,
    input wire hpf_pkg::hpf_ann_class_t ann_class,
    input wire logic transmit_ack_packet,
    output hpf_pkg::hpf_cut_t cut,
    output hpf_pkg::hpf_char_t notice_char,
    output logic hop_tx_allow,
    output logic ann_emit,
    output logic reply_emit,
    output logic structured_active,
    output logic irq
);
    localparam int PRE_W = $clog2(CYCLES_PER_MS + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYCLES_PER_MS - 1);
    localparam logic [2:0] NOTICE_LAST = 3'(hpf_pkg::HPF_NOTICE_LEN - 1);

    typedef struct packed {
        logic [7:0] framing;
        logic [7:0] opts;
        logic [7:0] gap;
        logic [7:0] thresh;
        logic [7:0] notice_en;
        logic [7:0] link_en;
        logic [7:0] escape;
        logic [7:0] dest_sel;
        logic [7:0] hop_lim;
        logic [hpf_pkg::HPF_ST_W-1:0] status;
        logic [hpf_pkg::HPF_ST_W-1:0] mask;
        logic switched;
        logic startup_open;
        logic [7:0] byte_cnt;
        logic [PRE_W-1:0] pre;
        logic [7:0] ms_cnt;
        logic link_prev;
        logic pend_link;
        logic pend_drop;
        hpf_pkg::hpf_notice_state_t nstate;
        logic [2:0] nidx;
        logic ndrop;
        logic [1:0] hop_cnt;
        logic [7:0] last_remote;
        logic [7:0] rdata;
        hpf_pkg::hpf_cut_t cut;
        hpf_pkg::hpf_char_t notice;
        logic hop_allow;
        logic ann;
        logic reply;
        logic active;
        logic irq;
    } hpf_state_t;

    hpf_state_t s_q;
    hpf_state_t s_d;

    function automatic logic [7:0] hpf_notice_byte(input logic drop, input logic [2:0] idx);
        logic [7:0] c;
        c = 8'h3C;
        unique case (idx)
            3'h0: c = 8'h3C;
            3'h1: c = drop ? 8'h44 : 8'h4C;
            3'h2: c = drop ? 8'h52 : 8'h49;
            3'h3: c = drop ? 8'h4F : 8'h4E;
            3'h4: c = drop ? 8'h50 : 8'h4B;
            3'h5: c = 8'h3E;
            default: c = 8'h3E;
        endcase
        return c;
    endfunction

    logic structured;
    logic [1:0] hop_eff;
    logic [7:0] thresh_eff;
    logic [hpf_pkg::HPF_ST_W-1:0] ev;
    logic cut_now;
    logic gap_hit;
    logic ms_tick;

    always_comb begin
        s_d = s_q;
        ev = '0;
        // serial peripheral mode leaves only structured framing
        structured = s_q.framing[0] | s_q.switched | spi_mode; // R1 R11
        // out-of-range limit settings are clamped into 1..3
        hop_eff = (s_q.hop_lim == 8'h00) ? 2'h1 :
                  (s_q.hop_lim > 8'(hpf_pkg::HPF_HOP_MAX)) ? hpf_pkg::HPF_HOP_MAX :
                  s_q.hop_lim[1:0];
        thresh_eff = (s_q.thresh == 8'h00) ? 8'h01 : s_q.thresh;
        ms_tick = (s_q.pre == PRE_LAST);
        gap_hit = (s_q.gap != 8'h00) && (s_q.ms_cnt >= s_q.gap) && (s_q.byte_cnt != 8'h00); // R4 R13
        cut_now = 1'b0;

        // register bus
        s_d.rdata = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                hpf_pkg::HPF_OFS_FRAMING: s_d.rdata = s_q.framing;
                hpf_pkg::HPF_OFS_OPTS: s_d.rdata = s_q.opts;
                hpf_pkg::HPF_OFS_GAP: s_d.rdata = s_q.gap;
                hpf_pkg::HPF_OFS_THRESH: s_d.rdata = s_q.thresh;
                hpf_pkg::HPF_OFS_NOTICE: s_d.rdata = s_q.notice_en;
                hpf_pkg::HPF_OFS_LINKEN: s_d.rdata = s_q.link_en;
                hpf_pkg::HPF_OFS_ESCAPE: s_d.rdata = s_q.escape;
                hpf_pkg::HPF_OFS_DEST: s_d.rdata = s_q.dest_sel;
                hpf_pkg::HPF_OFS_HOPLIM: s_d.rdata = s_q.hop_lim;
                hpf_pkg::HPF_OFS_STATUS: s_d.rdata = {4'h0, s_q.status};
                hpf_pkg::HPF_OFS_MASK: s_d.rdata = {4'h0, s_q.mask};
                default: s_d.rdata = 8'h00;
            endcase
        end
        if (reg_write) begin
            unique case (reg_addr)
                hpf_pkg::HPF_OFS_FRAMING: s_d.framing = {7'h00, reg_wdata[0]}; // R1
                hpf_pkg::HPF_OFS_OPTS: s_d.opts = reg_wdata & hpf_pkg::HPF_OPTS_MASK; // R2
                hpf_pkg::HPF_OFS_GAP: s_d.gap = reg_wdata;
                hpf_pkg::HPF_OFS_THRESH: s_d.thresh = reg_wdata;
                hpf_pkg::HPF_OFS_NOTICE: s_d.notice_en = reg_wdata & hpf_pkg::HPF_NOTICE_MASK; // R3
                hpf_pkg::HPF_OFS_LINKEN: s_d.link_en = {7'h00, reg_wdata[0]};
                hpf_pkg::HPF_OFS_ESCAPE: s_d.escape = reg_wdata;
                hpf_pkg::HPF_OFS_DEST: s_d.dest_sel = {7'h00, reg_wdata[0]};
                hpf_pkg::HPF_OFS_HOPLIM: s_d.hop_lim = reg_wdata;
                hpf_pkg::HPF_OFS_MASK: s_d.mask = reg_wdata[hpf_pkg::HPF_ST_W-1:0];
                default: ;
            endcase
        end

        // switch command acceptance
        if (host_char.valid) begin
            s_d.startup_open = 1'b0;
        end
        if (switch_to_structured_cmd) begin
            if ((s_q.escape == hpf_pkg::HPF_ESC_ANYTIME) ||
                ((s_q.escape == hpf_pkg::HPF_ESC_STARTUP) && s_q.startup_open)) begin // R7
                s_d.switched = 1'b1; // R10
                ev[hpf_pkg::HPF_ST_SWITCH] = 1'b1;
            end else begin
                ev[hpf_pkg::HPF_ST_REFUSED] = 1'b1;
            end
            s_d.startup_open = 1'b0;
        end else if (return_transparent_cmd) begin
            s_d.switched = 1'b0; // R10
        end

        // transparent packet cutting
        s_d.cut.trigger = 1'b0;
        if (!structured) begin
            s_d.pre = ms_tick ? '0 : s_q.pre + PRE_W'(1);
            if (ms_tick && (s_q.ms_cnt != 8'hFF)) begin
                s_d.ms_cnt = s_q.ms_cnt + 8'h01;
            end
            if (host_char.valid) begin
                // a silent gap already reached cuts before this char is counted
                if (gap_hit) begin
                    cut_now = 1'b1;
                    s_d.byte_cnt = 8'h01;
                end else begin
                    s_d.byte_cnt = s_q.byte_cnt + 8'h01;
                end
                s_d.pre = '0; // R4
                s_d.ms_cnt = 8'h00;
                if (!gap_hit && (s_q.byte_cnt + 8'h01 >= thresh_eff)) begin // R5
                    cut_now = 1'b1;
                    s_d.byte_cnt = 8'h00;
                end
            end else if (gap_hit) begin
                cut_now = 1'b1; // R4
                s_d.byte_cnt = 8'h00;
            end
            if (cut_now) begin
                s_d.cut.trigger = 1'b1;
                s_d.cut.len = (gap_hit && !host_char.valid) ? s_q.byte_cnt :
                              gap_hit ? s_q.byte_cnt : s_q.byte_cnt + 8'h01;
                s_d.cut.dest = s_q.dest_sel[0] ? s_q.last_remote : hpf_pkg::HPF_BROADCAST; // R8
                ev[hpf_pkg::HPF_ST_CUT] = 1'b1;
            end
        end else begin
            s_d.byte_cnt = 8'h00;
            s_d.pre = '0;
            s_d.ms_cnt = 8'h00;
        end
        if (remote_registered) begin
            s_d.last_remote = remote_addr; // R8
        end

        // link strings, latched if the link changes while one is being sent
        s_d.link_prev = link_up;
        if (!structured && s_q.link_en[0] && (link_up != s_q.link_prev)) begin // R6
            if (link_up) begin
                s_d.pend_link = 1'b1;
            end else begin
                s_d.pend_drop = 1'b1;
            end
        end
        s_d.notice.valid = 1'b0;
        unique case (s_q.nstate)
            hpf_pkg::HPF_N_IDLE: begin
                if (s_q.pend_link || s_q.pend_drop) begin
                    s_d.ndrop = !s_q.pend_link;
                    if (s_q.pend_link) begin
                        s_d.pend_link = 1'b0;
                    end else begin
                        s_d.pend_drop = 1'b0;
                    end
                    s_d.nidx = 3'h0;
                    s_d.nstate = hpf_pkg::HPF_N_SEND;
                end
            end
            hpf_pkg::HPF_N_SEND: begin
                s_d.notice.valid = 1'b1; // R6
                s_d.notice.data = hpf_notice_byte(s_q.ndrop, s_q.nidx);
                s_d.nidx = s_q.nidx + 3'h1;
                if (s_q.nidx == NOTICE_LAST) begin
                    s_d.nstate = hpf_pkg::HPF_N_IDLE;
                end
            end
            default: s_d.nstate = hpf_pkg::HPF_N_IDLE;
        endcase

        // per-hop packet budget
        if (hop_start) begin
            s_d.hop_cnt = 2'h0;
        end else if (packet_sent && (s_q.hop_cnt < hop_eff)) begin
            s_d.hop_cnt = s_q.hop_cnt + 2'h1;
            if (s_q.hop_cnt + 2'h1 == hop_eff) begin
                ev[hpf_pkg::HPF_ST_HOPFULL] = 1'b1;
            end
        end
        s_d.hop_allow = (s_d.hop_cnt < hop_eff); // R9

        // structured notices
        s_d.ann = structured && ann_request && s_q.opts[hpf_pkg::HPF_OPT_ANN_BIT] &&
                  s_q.notice_en[ann_class]; // R12 R3 R2
        s_d.reply = structured && transmit_ack_packet &&
                    s_q.opts[hpf_pkg::HPF_OPT_REPLY_BIT]; // R2
        s_d.active = structured;

        // sticky status, write one to clear, a new event wins over the clear
        if (reg_write && (reg_addr == hpf_pkg::HPF_OFS_STATUS)) begin
            s_d.status = s_q.status & ~reg_wdata[hpf_pkg::HPF_ST_W-1:0];
        end
        s_d.status = s_d.status | ev;
        s_d.irq = |(s_d.status & s_d.mask);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_q <= '0;
            s_q.framing <= hpf_pkg::HPF_RST_FRAMING;
            s_q.opts <= hpf_pkg::HPF_RST_OPTS;
            s_q.gap <= hpf_pkg::HPF_RST_GAP;
            s_q.thresh <= hpf_pkg::HPF_RST_THRESH;
            s_q.notice_en <= hpf_pkg::HPF_RST_NOTICE;
            s_q.link_en <= hpf_pkg::HPF_RST_LINKEN;
            s_q.escape <= hpf_pkg::HPF_RST_ESCAPE;
            s_q.dest_sel <= hpf_pkg::HPF_RST_DEST;
            s_q.hop_lim <= hpf_pkg::HPF_RST_HOPLIM;
            s_q.startup_open <= 1'b1;
            s_q.hop_allow <= 1'b1;
            s_q.nstate <= hpf_pkg::HPF_N_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign cut = s_q.cut;
    assign notice_char = s_q.notice;
    assign hop_tx_allow = s_q.hop_allow;
    assign ann_emit = s_q.ann;
    assign reply_emit = s_q.reply;
    assign structured_active = s_q.active;
    assign irq = s_q.irq;
endmodule
`default_nettype wire

// [src/hpf_pkg.sv]
// package of register map, field layout, reset values and timing for the host framer
// Overview of operation
// R1: framing select: 0 transparent, 1 structured
// R2: options bit2 reply output, bit0 announcements
// R3: notice enables: error, link, init classes
// R4: transparent gap timeout in ms ends message
// R5: byte count reaching threshold triggers transmission
// R6: transparent link strings <LINK> and <DROP>
// R7: switch command: never, startup only, anytime
// R8: destination broadcast or last registered remote
// R9: per-hop packets limited to setting 1..3
// R10: host may send switch command, later return
// R11: serial peripheral mode forces structured framing
// R12: announcement needs global and class enable
// R13: zero timeout disables gap detection
package hpf_pkg;
    localparam logic [7:0] HPF_OFS_FRAMING = 8'h00;
    localparam logic [7:0] HPF_OFS_OPTS = 8'h01;
    localparam logic [7:0] HPF_OFS_GAP = 8'h02;
    localparam logic [7:0] HPF_OFS_THRESH = 8'h03;
    localparam logic [7:0] HPF_OFS_NOTICE = 8'h04;
    localparam logic [7:0] HPF_OFS_LINKEN = 8'h05;
    localparam logic [7:0] HPF_OFS_ESCAPE = 8'h06;
    localparam logic [7:0] HPF_OFS_DEST = 8'h07;
    localparam logic [7:0] HPF_OFS_HOPLIM = 8'h08;
    localparam logic [7:0] HPF_OFS_STATUS = 8'h09;
    localparam logic [7:0] HPF_OFS_MASK = 8'h0A;
    localparam logic [7:0] HPF_RST_FRAMING = 8'h00;
    localparam logic [7:0] HPF_RST_OPTS = 8'h05;
    localparam logic [7:0] HPF_RST_GAP = 8'h00;
    localparam logic [7:0] HPF_RST_THRESH = 8'h01;
    localparam logic [7:0] HPF_RST_NOTICE = 8'h07;
    localparam logic [7:0] HPF_RST_LINKEN = 8'h00;
    localparam logic [7:0] HPF_RST_ESCAPE = 8'h02;
    localparam logic [7:0] HPF_RST_DEST = 8'h00;
    localparam logic [7:0] HPF_RST_HOPLIM = 8'h03;
    localparam int HPF_OPT_REPLY_BIT = 2;
    localparam int HPF_OPT_ANN_BIT = 0;
    localparam logic [7:0] HPF_OPTS_MASK = 8'h05;
    localparam logic [7:0] HPF_NOTICE_MASK = 8'h07;
    localparam logic [7:0] HPF_ESC_NEVER = 8'h00;
    localparam logic [7:0] HPF_ESC_STARTUP = 8'h01;
    localparam logic [7:0] HPF_ESC_ANYTIME = 8'h02;
    localparam logic [1:0] HPF_HOP_MAX = 2'h3;
    localparam logic [7:0] HPF_BROADCAST = 8'hFF;
    // status bit positions
    localparam int HPF_ST_CUT = 0;
    localparam int HPF_ST_SWITCH = 1;
    localparam int HPF_ST_HOPFULL = 2;
    localparam int HPF_ST_REFUSED = 3;
    localparam int HPF_ST_W = 4;
    // timing
    localparam int HPF_CLK_PERIOD_NS = 10;
    localparam int HPF_MS_NS = 1000000;
    localparam int HPF_CYCLES_PER_MS = HPF_MS_NS / HPF_CLK_PERIOD_NS;
    localparam int HPF_NOTICE_LEN = 6;
    typedef enum logic [1:0] {
        HPF_ANN_INIT = 2'h0,
        HPF_ANN_LINK = 2'h1,
        HPF_ANN_ERROR = 2'h2
    } hpf_ann_class_t;
    typedef enum logic [1:0] {
        HPF_N_IDLE = 2'b00,
        HPF_N_SEND = 2'b01
    } hpf_notice_state_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } hpf_char_t;
    typedef struct packed {
        logic trigger;
        logic [7:0] len;
        logic [7:0] dest;
    } hpf_cut_t;
endpackage

// [verification/hpf_framer_sva.sv]
// port checker of the host framer
`timescale 1ns/1ps
`default_nettype none
module hpf_framer_sva #(
    parameter int CYCLES_PER_MS = hpf_pkg::HPF_CYCLES_PER_MS
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic spi_mode,
    input wire logic ann_request,
    input wire logic transmit_ack_packet,
    input wire logic hop_start,
    input wire logic packet_sent,
    input wire hpf_pkg::hpf_cut_t cut,
    input wire hpf_pkg::hpf_char_t notice_char,
    input wire logic hop_tx_allow,
    input wire logic ann_emit,
    input wire logic reply_emit,
    input wire logic structured_active
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_hop_three;
        hop_start ##1 (packet_sent && !hop_start)[*3];
    endsequence
    sequence s_notice_run;
        (notice_char.valid && notice_char.data == 8'h3C) ##1 notice_char.valid[*5];
    endsequence
    a_spi_structured:
        assert property (spi_mode[*3] |-> structured_active)
        else $error("peripheral mode without structured framing");
    a_cut_transparent:
        assert property (cut.trigger |-> !structured_active)
        else $error("packet cut in structured framing");
    a_ann_gated:
        assert property (ann_emit |-> $past(ann_request) && structured_active)
        else $error("announcement without request in structured framing");
    a_reply_gated:
        assert property (reply_emit |-> $past(transmit_ack_packet) && structured_active)
        else $error("reply without request in structured framing");
    a_hop_restore:
        assert property (hop_start && !packet_sent |=> hop_tx_allow)
        else $error("new hop did not restore sending");
    a_hop_limit:
        assert property (s_hop_three |=> !hop_tx_allow)
        else $error("more than three packets allowed in one hop");
    a_notice_run:
        assert property ($rose(notice_char.valid) |-> s_notice_run)
        else $error("link string not six characters from an opening bracket");
    a_notice_mode:
        assert property ($rose(notice_char.valid) |-> !structured_active)
        else $error("link string in structured framing");
endmodule
bind hpf_framer hpf_framer_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) i_hpf_framer_sva (
    .clock, .reset, .spi_mode, .ann_request, .transmit_ack_packet, .hop_start, .packet_sent,
    .cut, .notice_char, .hop_tx_allow, .ann_emit, .reply_emit, .structured_active);
`default_nettype wire

// [verification/hpf_host_model.sv]
// host processor model: characters and framing commands
`timescale 1ns/1ps
`default_nettype none
module hpf_host_model (
    input wire logic clock,
    output hpf_pkg::hpf_char_t host_char,
    output logic switch_to_structured_cmd,
    output logic return_transparent_cmd
);
    logic [7:0] next_q = 8'h41;
    initial begin
        host_char = '{valid: 1'b0, data: 8'hBE};
        switch_to_structured_cmd = 1'b0;
        return_transparent_cmd = 1'b0;
    end
    // idle data is inverted so a stale byte never looks valid
    task automatic send(input int n, input int space);
        for (int k = 0; k < n; k++) begin
            @(posedge clock);
            host_char <= '{valid: 1'b1, data: next_q};
            next_q <= next_q + 8'h01;
            // no trailing space after the last char, so a one-cycle cut is still visible
            if (space > 0 && k < n - 1) begin
                @(posedge clock);
                host_char <= '{valid: 1'b0, data: ~host_char.data};
                repeat (space - 1) @(posedge clock);
            end
        end
        @(posedge clock);
        host_char <= '{valid: 1'b0, data: ~host_char.data};
    endtask
    task automatic command(input logic back);
        @(posedge clock);
        if (back) begin
            return_transparent_cmd <= 1'b1;
        end else begin
            switch_to_structured_cmd <= 1'b1;
        end
        @(posedge clock);
        return_transparent_cmd <= 1'b0;
        switch_to_structured_cmd <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [verification/tb_hpf_framer.sv]
// self-checking bench of the host framer
`timescale 1ns/1ps
`default_nettype none
module tb_hpf_framer;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic spi_mode = 1'b0;
    logic link_up = 1'b0;
    logic remote_registered = 1'b0;
    logic [7:0] remote_addr = 8'h00;
    logic hop_start = 1'b0;
    logic packet_sent = 1'b0;
    logic ann_request = 1'b0;
    logic transmit_ack_packet = 1'b0;
    hpf_pkg::hpf_ann_class_t ann_class = hpf_pkg::HPF_ANN_INIT;
    logic [7:0] reg_rdata;
    hpf_pkg::hpf_char_t host_char, notice_char;
    logic switch_to_structured_cmd, return_transparent_cmd;
    hpf_pkg::hpf_cut_t cut;
    logic hop_tx_allow, ann_emit, reply_emit, structured_active, irq;
    int n_mismatch = 0;
    int total_checks = 0;
    always #5 clock = ~clock;
    hpf_framer #(.CYCLES_PER_MS(10)) i_hpf_framer (.clock, .reset, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .host_char, .spi_mode, .switch_to_structured_cmd,
        .return_transparent_cmd, .link_up, .remote_registered, .remote_addr, .hop_start,
        .packet_sent, .ann_request, .ann_class, .transmit_ack_packet, .cut, .notice_char,
        .hop_tx_allow, .ann_emit, .reply_emit, .structured_active, .irq);
    hpf_host_model i_hpf_host_model (.clock, .host_char, .switch_to_structured_cmd,
        .return_transparent_cmd);
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic rst;
        @(posedge clock);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        chk("reg_rdata", exp, reg_rdata);
    endtask
    // a cut that never comes ends the run instead of hanging
    task automatic wcut(input int lim, output int i);
        @(negedge clock);
        for (i = 0; i < lim && cut.trigger !== 1'b1; i++) @(negedge clock);
        if (i == lim) begin
            chk("cut_trigger", 8'h01, 8'h00);
            stop_test;
        end
    endtask
    task automatic cuts(output int h);
        h = 0;
        repeat (40) begin
            @(negedge clock);
            h += int'(cut.trigger === 1'b1);
        end
    endtask
    task automatic settle(input string what, input logic e, input logic got_sel);
        repeat (2) @(negedge clock);
        chk(what, 8'(e), got_sel ? 8'(irq) : 8'(structured_active));
    endtask
    task automatic t_regs;
        logic [7:0] rv [9] = '{8'h00, 8'h05, 8'h00, 8'h01, 8'h07, 8'h00, 8'h02, 8'h00, 8'h03};
        for (int i = 0; i < 9; i++) rd(8'(i), rv[i]);
        rd(8'h0F, 8'h00);
        wr(8'h01, 8'hFF);
        rd(8'h01, 8'h05);
        wr(8'h04, 8'hFA);
        rd(8'h04, 8'h02);
        wr(8'h04, 8'h07);
        wr(8'h01, 8'h05);
    endtask
    task automatic t_count;
        int n;
        i_hpf_host_model.send(1, 0);
        wcut(8, n);
        chk("cut_len", 8'h01, cut.len);
        chk("cut_dest", 8'hFF, cut.dest);
        wr(8'h03, 8'h03);
        i_hpf_host_model.send(3, 2);
        wcut(8, n);
        chk("cut_len", 8'h03, cut.len);
        wr(8'h07, 8'h01);
        @(posedge clock);
        remote_registered <= 1'b1;
        remote_addr <= 8'h5A;
        @(posedge clock);
        remote_registered <= 1'b0;
        i_hpf_host_model.send(3, 0);
        wcut(8, n);
        chk("cut_dest", 8'h5A, cut.dest);
    endtask
    task automatic t_gap;
        int n;
        rst;
        wr(8'h03, 8'h0A);
        wr(8'h02, 8'h02);
        i_hpf_host_model.send(2, 0);
        wcut(60, n);
        chk("gap_window", 8'h01, 8'(n >= 8 && n <= 32));
        chk("cut_len", 8'h02, cut.len);
        wr(8'h02, 8'h00);
        i_hpf_host_model.send(2, 0);
        cuts(n);
        chk("cut_count", 8'h00, 8'(n));
        rd(8'h09, 8'h01);
        settle("irq", 1'b0, 1'b1);
        wr(8'h0A, 8'h01);
        settle("irq", 1'b1, 1'b1);
        wr(8'h09, 8'h01);
        settle("irq", 1'b0, 1'b1);
    endtask
    task automatic notice(input logic [47:0] s);
        int i;
        @(negedge clock);
        for (i = 0; i < 10 && notice_char.valid !== 1'b1; i++) @(negedge clock);
        for (int k = 0; k < 6; k++) begin
            chk("notice_char", s[47 - 8 * k -: 8], notice_char.valid ? notice_char.data : 8'h00);
            @(negedge clock);
        end
    endtask
    task automatic t_escape;
        rst;
        wr(8'h06, 8'h00);
        i_hpf_host_model.command(1'b0);
        settle("structured", 1'b0, 1'b0);
        rd(8'h09, 8'h08);
        wr(8'h06, 8'h02);
        i_hpf_host_model.command(1'b0);
        settle("structured", 1'b1, 1'b0);
        i_hpf_host_model.command(1'b1);
        settle("structured", 1'b0, 1'b0);
        rst;
        wr(8'h06, 8'h01);
        i_hpf_host_model.command(1'b0);
        settle("structured", 1'b1, 1'b0);
        i_hpf_host_model.command(1'b1);
        i_hpf_host_model.command(1'b0);
        settle("structured", 1'b0, 1'b0);
    endtask
    task automatic hop_run(input int k, input logic e);
        @(posedge clock);
        hop_start <= 1'b1;
        @(posedge clock);
        hop_start <= 1'b0;
        for (int j = 0; j < k; j++) begin
            packet_sent <= 1'b1;
            @(posedge clock);
        end
        packet_sent <= 1'b0;
        repeat (2) @(negedge clock);
        chk("hop_tx_allow", 8'(e), 8'(hop_tx_allow));
    endtask
    task automatic req(input logic is_ack, input int c, input logic e);
        @(posedge clock);
        if (is_ack) begin
            transmit_ack_packet <= 1'b1;
        end else begin
            ann_request <= 1'b1;
        end
        ann_class <= hpf_pkg::hpf_ann_class_t'(c);
        @(posedge clock);
        transmit_ack_packet <= 1'b0;
        ann_request <= 1'b0;
        @(negedge clock);
        chk("emit", 8'(e), is_ack ? 8'(reply_emit) : 8'(ann_emit));
    endtask
    task automatic t_ann;
        rst;
        req(1'b0, 0, 1'b0);
        wr(8'h00, 8'h01);
        settle("structured", 1'b1, 1'b0);
        for (int c = 0; c < 3; c++) req(1'b0, c, 1'b1);
        wr(8'h04, 8'h05);
        req(1'b0, 1, 1'b0);
        wr(8'h01, 8'h04);
        req(1'b0, 0, 1'b0);
        req(1'b1, 0, 1'b1);
        wr(8'h01, 8'h01);
        req(1'b1, 0, 1'b0);
    endtask
    task automatic t_spi;
        int n;
        rst;
        @(posedge clock);
        spi_mode <= 1'b1;
        settle("structured", 1'b1, 1'b0);
        i_hpf_host_model.send(2, 0);
        cuts(n);
        chk("cut_count", 8'h00, 8'(n));
        @(posedge clock);
        spi_mode <= 1'b0;
    endtask
    initial begin
        rst;
        t_regs;
        t_count;
        t_gap;
        wr(8'h05, 8'h01);
        @(posedge clock);
        link_up <= 1'b1;
        notice("<LINK>");
        @(posedge clock);
        link_up <= 1'b0;
        notice("<DROP>");
        t_escape;
        wr(8'h08, 8'h02);
        hop_run(2, 1'b0);
        hop_run(0, 1'b1);
        wr(8'h08, 8'h00);
        hop_run(1, 1'b0);
        wr(8'h08, 8'h03);
        hop_run(2, 1'b1);
        hop_run(3, 1'b0);
        // a limit above 3 must act as 3, not as its low bits
        wr(8'h08, 8'h04);
        hop_run(2, 1'b1);
        rd(8'h09, 8'h0E);
        t_ann;
        t_spi;
        stop_test;
    end
endmodule
`default_nettype wire
